// >>> rtl/rcrb_regs.svh
`ifndef RCRB_REGS_SVH
`define RCRB_REGS_SVH

// Register addresses
`define RCRB_ADDR_CONFIG    5'h00
`define RCRB_ADDR_AUTO_ACK  5'h01
`define RCRB_ADDR_RX_PIPE   5'h02
`define RCRB_ADDR_ADDR_W    5'h03
`define RCRB_ADDR_RETRY     5'h04
`define RCRB_ADDR_STATUS    5'h07
`define RCRB_ADDR_TEST_LO   5'h18
`define RCRB_ADDR_TEST_HI   5'h1B

// Reset values
`define RCRB_RST_CONFIG     8'h08
`define RCRB_RST_AUTO_ACK   8'h3F
`define RCRB_RST_RX_PIPE    8'h03
`define RCRB_RST_ADDR_W     8'h03
`define RCRB_RST_RETRY      8'h03

// Writable-bit masks, reserved bits stay zero
`define RCRB_MASK_CONFIG    8'h7F
`define RCRB_MASK_PIPE      8'h3F
`define RCRB_MASK_ADDR_W    8'h03
`define RCRB_MASK_RETRY     8'hFF

// Status flag positions
`define RCRB_STS_RX_READY   6
`define RCRB_STS_TX_SENT    5
`define RCRB_STS_RETRY_EXH  4

// Command opcode in bits 7:5 of the first byte
`define RCRB_CMD_READ       3'h0
`define RCRB_CMD_WRITE      3'h1

// Frame bit positions
`define RCRB_BIT_CMD_LAST   4'h7
`define RCRB_BIT_DATA_LAST  4'hF

// Timing
`define RCRB_CLK_MHZ        100
`define RCRB_RETRY_STEP_US  250

`endif

// >>> rtl/rcrb_pkg.sv
package rcrb_pkg;

  // Configuration register fields
  typedef struct packed {
    logic rxReadyIrqMask;
    logic txSentIrqMask;
    logic retryLimitIrqMask;
    logic crcEnable;
    logic checkLengthSelect;
    logic powerOnBit;
    logic roleSelect;
  } rcrb_cfg_s;

  // Settings handed to the radio core
  typedef struct packed {
    rcrb_cfg_s  cfg;
    logic [5:0] pipeAutoAck;
    logic [5:0] pipeRxEnable;
    logic [1:0] addrWidthCode;
    logic [3:0] retryDelayCode;
    logic [3:0] retryLimit;
  } rcrb_ctl_s;

  // Event pulses from the radio core
  typedef struct packed {
    logic rxReadyFlag;
    logic txSentFlag;
    logic retryExhaustedFlag;
  } rcrb_evt_s;

  // Serial frame states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD  = 2'h1,
    ST_DATA = 2'h3,
    ST_DONE = 2'h2
  } rcrb_state_e;

endpackage

// >>> rtl/rcrb_top.sv
`timescale 1ns/10ps
`include "rcrb_regs.svh"

module rcrb_top #(
  parameter int RETRY_STEP_CYC = `RCRB_RETRY_STEP_US * `RCRB_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // Serial host pins
  input  wire logic                spiCsN,
  input  wire logic                spiSck,
  input  wire logic                spiMosi,
  output logic                     spiMisoOut,
  output logic                     spiMisoOe,
  // Radio core events and interrupt pin
  input  wire rcrb_pkg::rcrb_evt_s evt,
  output logic                     irqN,
  // Settings to the radio core
  output rcrb_pkg::rcrb_ctl_s      ctl,
  output logic                     crcActive,
  output logic                     retryEnable,
  output logic [18:0]              retryDelayCycles,
  // Stored pipe address and its used part
  input  wire logic [39:0]         storedAddr,
  output logic [39:0]              activeAddr
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check

  // Delay product must fit the 19-bit output
  if (RETRY_STEP_CYC < 1 || RETRY_STEP_CYC * 16 >= (1 << 19)) begin : g_badStep
    $error("RETRY_STEP_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pinSync1_r;   // First stage, read only by second
  logic [2:0] pinSync2_r;   // Second stage, safe to use
  logic       sckPrev_r;    // Previous clock level for edges

  // Two flops on csn, sck, mosi
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle pin levels: deselected, clock low, so no false edge
      pinSync1_r <= 3'h4;
      pinSync2_r <= 3'h4;
      sckPrev_r  <= 1'b0;
    end else begin
      pinSync1_r <= {spiCsN, spiSck, spiMosi};
      pinSync2_r <= pinSync1_r;
      sckPrev_r  <= pinSync2_r[1];
    end
  end

  wire csnS    = pinSync2_r[2];          // Chip select, active low
  wire sckS    = pinSync2_r[1];          // Serial clock level
  wire mosiS   = pinSync2_r[0];          // Serial data in
  wire sckRise = sckS & ~sckPrev_r;      // Sample edge
  wire sckFall = ~sckS & sckPrev_r;      // Shift-out edge

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  rcrb_pkg::rcrb_cfg_s cfg_r;            // Configuration register
  logic [5:0]          autoAck_r;        // Auto-ack enables per pipe
  logic [5:0]          rxPipe_r;         // Receive enables per pipe
  logic [1:0]          addrW_r;          // Address width code
  logic [7:0]          retry_r;          // Delay and count codes
  logic [2:0]          flags_r;          // Sticky interrupt flags
  logic [2:0]          flags_nxt;        // Next flag value

  ////////////////////////////////////////////////////////////////////////
  // Serial frame state

  rcrb_pkg::rcrb_state_e state_r;        // Frame state
  logic [3:0]            bitCnt_r;       // Bits taken in this frame
  logic [7:0]            rxShift_r;      // Incoming bits
  logic [7:0]            txShift_r;      // Outgoing bits
  logic                  miso_r;         // Registered output bit
  logic [2:0]            opcode_r;       // Command opcode
  logic [4:0]            regAddr_r;      // Command address

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Command and data bytes as they complete
  wire [7:0] inByte     = {rxShift_r[6:0], mosiS};
  wire       cmdDone    = (state_r == rcrb_pkg::ST_CMD) && sckRise
                          && (bitCnt_r == `RCRB_BIT_CMD_LAST);
  wire       dataDone   = (state_r == rcrb_pkg::ST_DATA) && sckRise
                          && (bitCnt_r == `RCRB_BIT_DATA_LAST);
  wire       isWrite    = (opcode_r == `RCRB_CMD_WRITE);
  wire       isRead     = (inByte[7:5] == `RCRB_CMD_READ);

  // Test block addresses never take a write
  wire       testAddr   = (regAddr_r >= `RCRB_ADDR_TEST_LO)
                          && (regAddr_r <= `RCRB_ADDR_TEST_HI);
  wire       wrStrobe   = dataDone && isWrite && !testAddr;

  // Per-register write enables
  wire       wrConfig   = wrStrobe && (regAddr_r == `RCRB_ADDR_CONFIG);
  wire       wrAutoAck  = wrStrobe && (regAddr_r == `RCRB_ADDR_AUTO_ACK);
  wire       wrRxPipe   = wrStrobe && (regAddr_r == `RCRB_ADDR_RX_PIPE);
  wire       wrAddrW    = wrStrobe && (regAddr_r == `RCRB_ADDR_ADDR_W);
  wire       wrRetry    = wrStrobe && (regAddr_r == `RCRB_ADDR_RETRY);
  wire       wrStatus   = wrStrobe && (regAddr_r == `RCRB_ADDR_STATUS);

  // Masked write data, reserved bits dropped
  wire [7:0] wdConfig   = inByte & `RCRB_MASK_CONFIG;
  wire [7:0] wdPipe     = inByte & `RCRB_MASK_PIPE;
  wire [7:0] wdAddrW    = inByte & `RCRB_MASK_ADDR_W;

  // CRC reads forced high while any auto-ack bit is on
  wire       crcForced  = cfg_r.crcEnable | (|autoAck_r);

  // Read-back values, unused bits zero
  wire [7:0] rdConfig   = {1'b0, cfg_r.rxReadyIrqMask, cfg_r.txSentIrqMask,
                           cfg_r.retryLimitIrqMask, crcForced,
                           cfg_r.checkLengthSelect, cfg_r.powerOnBit,
                           cfg_r.roleSelect};
  wire [7:0] rdStatus   = {1'b0, flags_r, 4'h0};
  wire [4:0] rdAddr     = inByte[4:0];
  wire [7:0] rdData     =
      (rdAddr == `RCRB_ADDR_CONFIG)   ? rdConfig :
      (rdAddr == `RCRB_ADDR_AUTO_ACK) ? {2'h0, autoAck_r} :
      (rdAddr == `RCRB_ADDR_RX_PIPE)  ? {2'h0, rxPipe_r} :
      (rdAddr == `RCRB_ADDR_ADDR_W)   ? {6'h00, addrW_r} :
      (rdAddr == `RCRB_ADDR_RETRY)    ? retry_r :
      (rdAddr == `RCRB_ADDR_STATUS)   ? rdStatus :
                                        8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Frame state machine

  // Tracks command byte, data byte, then idles to deselect
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= rcrb_pkg::ST_IDLE;
      bitCnt_r  <= 4'h0;
      rxShift_r <= 8'h00;
      opcode_r  <= 3'h0;
      regAddr_r <= 5'h00;
    end else if (csnS) begin
      // Deselect aborts any frame
      state_r  <= rcrb_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
    end else begin
      if (sckRise) begin
        rxShift_r <= inByte;
        bitCnt_r  <= bitCnt_r + 4'h1;
      end
      case (state_r)
        rcrb_pkg::ST_IDLE: begin
          // Select seen
          state_r <= rcrb_pkg::ST_CMD;
        end
        rcrb_pkg::ST_CMD: begin
          // Latch opcode and address
          if (cmdDone) begin
            opcode_r  <= inByte[7:5];
            regAddr_r <= inByte[4:0];
            state_r   <= rcrb_pkg::ST_DATA;
          end
        end
        rcrb_pkg::ST_DATA: begin
          // Data byte taken, extra bits ignored
          if (dataDone) begin
            state_r <= rcrb_pkg::ST_DONE;
          end
        end
        rcrb_pkg::ST_DONE: begin
          // Wait for deselect
          state_r <= rcrb_pkg::ST_DONE;
        end
        default: begin
          state_r <= rcrb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  // Status on command byte, register on data byte of a read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_r <= 8'h00;
      miso_r    <= 1'b0;
    end else if (state_r == rcrb_pkg::ST_IDLE && !csnS) begin
      miso_r    <= rdStatus[7];
      txShift_r <= {rdStatus[6:0], 1'b0};
    end else if (cmdDone) begin
      txShift_r <= isRead ? rdData : 8'h00;
    end else if (sckFall && !csnS) begin
      miso_r    <= txShift_r[7];
      txShift_r <= {txShift_r[6:0], 1'b0};
    end
  end

  // Drive data pin only while selected
  assign spiMisoOut = miso_r;
  assign spiMisoOe  = ~csnS;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Host writes; reserved bits masked off
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r     <= rcrb_pkg::rcrb_cfg_s'(7'(`RCRB_RST_CONFIG));
      autoAck_r <= 6'(`RCRB_RST_AUTO_ACK);
      rxPipe_r  <= 6'(`RCRB_RST_RX_PIPE);
      addrW_r   <= 2'(`RCRB_RST_ADDR_W);
      retry_r   <= `RCRB_RST_RETRY;
    end else begin
      if (wrConfig) begin
        cfg_r <= rcrb_pkg::rcrb_cfg_s'(wdConfig[6:0]);
      end
      if (wrAutoAck) begin
        autoAck_r <= wdPipe[5:0];
      end
      if (wrRxPipe) begin
        rxPipe_r <= wdPipe[5:0];
      end
      if (wrAddrW) begin
        addrW_r <= wdAddrW[1:0];
      end
      if (wrRetry) begin
        retry_r <= inByte & `RCRB_MASK_RETRY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags and pin

  // Event sets beat a same-cycle write-one clear
  wire [2:0] flagSet = {evt.rxReadyFlag, evt.txSentFlag, evt.retryExhaustedFlag};
  wire [2:0] flagClr = wrStatus ? {inByte[`RCRB_STS_RX_READY],
                                   inByte[`RCRB_STS_TX_SENT],
                                   inByte[`RCRB_STS_RETRY_EXH]} : 3'h0;
  assign flags_nxt = (flags_r & ~flagClr) | flagSet;

  // Masked sources kept off the pin
  wire [2:0] irqMask = {cfg_r.rxReadyIrqMask, cfg_r.txSentIrqMask,
                        cfg_r.retryLimitIrqMask};
  wire       irqAny  = |(flags_nxt & ~irqMask);

  // Flags and active-low pin from flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 3'h0;
      irqN    <= 1'b1;
    end else begin
      flags_r <= flags_nxt;
      irqN    <= ~irqAny;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Derived settings

  // Byte mask for the address width in use
  wire [39:0] addrMask =
      (addrW_r == 2'h1) ? 40'h00_00FF_FFFF :
      (addrW_r == 2'h2) ? 40'h00_FFFF_FFFF :
                          40'hFF_FFFF_FFFF;

  // Delay in cycles, (code+1) steps
  wire [31:0] delayFull = (32'(retry_r[7:4]) + 32'h0000_0001)
                          * 32'(RETRY_STEP_CYC);

  // Registered outputs to the radio core
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      activeAddr       <= 40'h00_0000_0000;
      retryDelayCycles <= 19'h0_0000;
      retryEnable      <= 1'b0;
      crcActive        <= 1'b0;
    end else begin
      activeAddr       <= storedAddr & addrMask;
      retryDelayCycles <= delayFull[18:0];
      retryEnable      <= |retry_r[3:0];
      crcActive        <= crcForced;
    end
  end

  // Configuration as the core sees it, check enable forced
  wire rcrb_pkg::rcrb_cfg_s cfgView = '{rxReadyIrqMask:    cfg_r.rxReadyIrqMask,
                                        txSentIrqMask:     cfg_r.txSentIrqMask,
                                        retryLimitIrqMask: cfg_r.retryLimitIrqMask,
                                        crcEnable:         crcForced,
                                        checkLengthSelect: cfg_r.checkLengthSelect,
                                        powerOnBit:        cfg_r.powerOnBit,
                                        roleSelect:        cfg_r.roleSelect};

  // Settings bundle straight from registers, one driver
  assign ctl = '{cfg:            cfgView,
                 pipeAutoAck:    autoAck_r,
                 pipeRxEnable:   rxPipe_r,
                 addrWidthCode:  addrW_r,
                 retryDelayCode: retry_r[7:4],
                 retryLimit:     retry_r[3:0]};

endmodule

// >>> testbench/rcrb_top_asserts.sv
`timescale 1ns/10ps
module rcrb_top_asserts #(
  parameter int RETRY_STEP_CYC = 25000
) (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                arst_n,
  // Serial pins
  input wire logic                spiCsN,
  input wire logic                spiMisoOe,
  // Events and interrupt pin
  input wire rcrb_pkg::rcrb_evt_s evt,
  input wire logic                irqN,
  // Settings
  input wire rcrb_pkg::rcrb_ctl_s ctl,
  input wire logic                retryEnable,
  input wire logic [18:0]         retryDelayCycles,
  input wire logic [39:0]         storedAddr,
  input wire logic [39:0]         activeAddr
);
  logic       live_r;  // High once registered outputs left reset
  wire  [2:0] irqMask; // Masks in event order
  assign irqMask = {ctl.cfg.rxReadyIrqMask, ctl.cfg.txSentIrqMask, ctl.cfg.retryLimitIrqMask};
  ////////////////////////////////////////////////////////////////////////////////
  // Skips the first edge, where outputs still hold reset values
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end
  // Bytes kept per width code
  function automatic logic [39:0] keep(input logic [1:0] w);
    case (w)
      2'h1:    keep = 40'h00_00FF_FFFF;
      2'h2:    keep = 40'h00_FFFF_FFFF;
      default: keep = 40'hFF_FFFF_FFFF;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Select taken, then held
  sequence selOpen;
    $fell(spiCsN) ##1 !spiCsN [*3];
  endsequence
  // Deselect held past the sync flops
  sequence selShut;
    spiCsN [*3];
  endsequence
  irq_set_a: assert property (|(evt & ~irqMask) |=> !irqN)
    else $error("interrupt pin not pulled low");
  irq_mask_a: assert property (&irqMask |=> irqN)
    else $error("masked source reached interrupt pin");
  irq_quiet_a: assert property (irqN && evt == 3'h0 && $stable(irqMask) |=> irqN)
    else $error("interrupt pin fell without cause");
  crc_forced_a: assert property (|ctl.pipeAutoAck |-> ctl.cfg.crcEnable)
    else $error("check enable not forced");
  retry_en_a: assert property (live_r |-> retryEnable == ($past(ctl.retryLimit) != 4'h0))
    else $error("retry enable wrong");
  retry_delay_a: assert property (live_r |-> retryDelayCycles ==
    (19'($past(ctl.retryDelayCode)) + 19'h1) * 19'(RETRY_STEP_CYC))
    else $error("retry delay wrong");
  addr_used_a: assert property (live_r |->
    activeAddr == ($past(storedAddr) & keep($past(ctl.addrWidthCode))))
    else $error("used address bytes wrong");
  oe_start_a: assert property (selOpen |-> spiMisoOe)
    else $error("output not enabled when selected");
  oe_off_a: assert property (selShut |-> !spiMisoOe)
    else $error("output enabled while deselected");
endmodule
bind rcrb_top rcrb_top_asserts #(.RETRY_STEP_CYC(RETRY_STEP_CYC)) rcrb_top_asserts_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe),
  .evt(evt), .irqN(irqN), .ctl(ctl), .retryEnable(retryEnable),
  .retryDelayCycles(retryDelayCycles), .storedAddr(storedAddr), .activeAddr(activeAddr));

// >>> testbench/rcrb_host_model.sv
`timescale 1ns/10ps
module rcrb_host_model (
  // Host-driven pins
  output logic      csN,
  output logic      sck,
  output logic      mosi,
  // Device answer
  input  wire logic miso,
  input  wire logic oe
);
  // Idle: deselected, clock still and low
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Writable bits per address, reserved ones sent as zero
  function automatic logic [7:0] legal(input logic [4:0] a);
    case (a)
      5'h00:        legal = 8'h7F;
      5'h01, 5'h02: legal = 8'h3F;
      5'h03:        legal = 8'h03;
      5'h07:        legal = 8'h70;
      default:      legal = 8'hFF;
    endcase
  endfunction
  // One frame: command byte then data byte, MSB first, mode 0
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input int nBits,
                      output logic [15:0] rx);
    logic [15:0] tx;
    tx = {cmd, dat & legal(cmd[4:0])};
    rx = 16'h0000;
    if (cmd[7:5] == 3'h1 && cmd[4:2] == 3'h6) return;
    csN = 1'b0;
    #60;
    for (int i = 0; i < nBits; i++) begin
      mosi = tx[15-i];
      #62.5 sck = 1'b1;
      rx = {rx[14:0], oe ? miso : ~miso}; // Undriven line shows no stale bit
      #62.5 sck = 1'b0;
    end
    #62.5 csN = 1'b1;
    mosi = ~mosi; // Released line shows no stale data
    #100;
  endtask
endmodule

// >>> testbench/test_radio_config_register_bank.sv
`timescale 1ns/10ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin badCount++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module test_radio_config_register_bank;
  localparam int STEP = 4; // Short retry step
  logic                ref_clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                spiCsN, spiSck, spiMosi, spiMisoOut, spiMisoOe;
  logic                irqN, crcActive, retryEnable;
  rcrb_pkg::rcrb_evt_s evt = 3'h0;
  rcrb_pkg::rcrb_ctl_s ctl;
  logic [18:0]         retryDelayCycles;
  logic [39:0]         storedAddr = 40'hA1_B2C3_D4E5;
  logic [39:0]         activeAddr;
  logic [39:0]         expAddr [4] = '{40'hA1_B2C3_D4E5, 40'h00_00C3_D4E5,
                                       40'h00_B2C3_D4E5, 40'hA1_B2C3_D4E5};
  logic [15:0]         rx;
  int                  badCount = 0;
  int                  nTests = 0;
  always #5 ref_clk = ~ref_clk;
  rcrb_top #(.RETRY_STEP_CYC(STEP)) rcrb_top_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .spiCsN(spiCsN), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .evt(evt),
    .irqN(irqN), .ctl(ctl), .crcActive(crcActive), .retryEnable(retryEnable),
    .retryDelayCycles(retryDelayCycles), .storedAddr(storedAddr), .activeAddr(activeAddr));
  rcrb_host_model rcrb_host_model_i (
    .csN(spiCsN), .sck(spiSck), .mosi(spiMosi), .miso(spiMisoOut), .oe(spiMisoOe));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus access helpers
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    rcrb_host_model_i.xfer({3'h1, a}, d, 16, rx);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rcrb_host_model_i.xfer({3'h0, a}, 8'h00, 16, rx);
    `CHK(rx[7:0], e)
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [2:0] e);
    @(posedge ref_clk);
    #1 evt = rcrb_pkg::rcrb_evt_s'(e);
    @(posedge ref_clk);
    #1 evt = 3'h0;
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and unmapped read
  task automatic t_defaults;
    rd(5'h00, 8'h08);
    `CHK(rx[15:8], 8'h00)
    rd(5'h01, 8'h3F);
    rd(5'h02, 8'h03);
    rd(5'h03, 8'h03);
    rd(5'h04, 8'h03);
    rd(5'h05, 8'h00);
    `CHK(crcActive, 1'b1)
    `CHK(retryDelayCycles, 19'(STEP))
    $display("t_defaults done");
  endtask
  // Config fields, forced check enable, pipe registers, aborted frame
  task automatic t_config;
    wr(5'h00, 8'h77);
    rd(5'h00, 8'h7F);
    `CHK({ctl.cfg.powerOnBit, ctl.cfg.roleSelect}, 2'h3)
    `CHK(ctl.cfg.checkLengthSelect, 1'b1)
    wr(5'h01, 8'h00);
    rd(5'h00, 8'h77);
    `CHK(crcActive, 1'b0)
    wr(5'h01, 8'h21);
    rd(5'h01, 8'h21);
    `CHK(ctl.pipeAutoAck, 6'h21)
    wr(5'h02, 8'h3C);
    rd(5'h02, 8'h3C);
    rcrb_host_model_i.xfer(8'h20, 8'h00, 12, rx);
    rcrb_host_model_i.xfer(8'hE0, 8'h55, 16, rx);
    `CHK(rx[7:0], 8'h00)
    rd(5'h00, 8'h7F);
    wr(5'h00, 8'h08);
    `CHK(ctl.cfg, 7'h08)
    $display("t_config done");
  endtask
  // Each source: raise, read, clear, then masked and unmasked
  task automatic t_irq;
    logic [2:0] e;
    for (int i = 0; i < 3; i++) begin
      e = 3'h4 >> i;
      pulse(e);
      `CHK(irqN, 1'b0)
      rd(5'h07, {1'b0, e, 4'h0});
      wr(5'h07, 8'h70);
      `CHK(irqN, 1'b1)
      wr(5'h00, {1'b0, e, 4'h8});
      pulse(e);
      `CHK(irqN, 1'b1)
      wr(5'h00, 8'h08);
      `CHK(irqN, 1'b0)
      wr(5'h07, 8'h70);
      `CHK(irqN, 1'b1)
    end
    // All sources masked at once, flags still recorded
    wr(5'h00, 8'h78);
    pulse(3'h7);
    `CHK(irqN, 1'b1)
    rd(5'h07, 8'h70);
    wr(5'h07, 8'h70);
    wr(5'h00, 8'h08);
    `CHK(irqN, 1'b1)
    $display("t_irq done");
  endtask
  // Every width code against the used address bytes
  task automatic t_width;
    for (int w = 1; w < 5; w++) begin
      wr(5'h03, 8'(w % 4));
      rd(5'h03, 8'(w % 4));
      `CHK(activeAddr, expAddr[w % 4])
    end
    $display("t_width done");
  endtask
  // Longest delay with retries off, then delay code 1 (two steps) with most retries
  task automatic t_retry;
    wr(5'h04, 8'hF0);
    `CHK(retryDelayCycles, 19'(16 * STEP))
    `CHK(retryEnable, 1'b0)
    wr(5'h04, 8'h1F);
    rd(5'h04, 8'h1F);
    `CHK(retryDelayCycles, 19'(2 * STEP))
    `CHK({retryEnable, ctl.retryLimit}, 5'h1F)
    $display("t_retry done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_defaults();
    t_config();
    t_irq();
    t_width();
    t_retry();
    conclude();
  end
  // Hang guard
  initial begin
    #500000;
    badCount++;
    conclude();
  end
endmodule
